// file: shared/scp_regs.svh
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// pad b positions within one channel group, group stride per channel
`define SCP_P_RX 0
`define SCP_P_TX 1
`define SCP_P_BCLK 2
`define SCP_P_CTS 3
`define SCP_CH_STRIDE 4
// pad c positions, channel 1 completion outputs
`define SCP_C_RXI 0
`define SCP_C_TXI 1
// selection defaults after reset: every pin is a port pin
`define SCP_BSEL_RST 8'h00
`define SCP_CSEL_RST 2'h0
// timing counts in sample ticks and bits; transmit idle shift value
`define SCP_OVS_LAST 4'hF
`define SCP_MID 4'h7
`define SCP_AFRAME_LAST 4'h9
`define SCP_SBIT_LAST 4'h7
`define SCP_TX_IDLE_SHIFT 10'h3FF
`endif

// file: shared/scp_pkg.sv
package scp_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC, TX_SRX} scp_tx_state_t;
    typedef enum logic {RX_IDLE, RX_BUSY} scp_rx_state_t;
endpackage

// file: logic/scp_fifo2.sv
`timescale 1ns/1ns
module scp_fifo2 (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [7:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] outData
);
    logic [7:0] mem_ff [2];
    logic wrPtr_ff;
    logic rdPtr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    assign inReady = (count_ff != 2'h2);
    assign outValid = (count_ff != 2'h0);
    assign outData = mem_ff[rdPtr_ff];
    assign push = ce & inValid & inReady;
    assign pop = ce & outValid & outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (pop) begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            case ({push, pop})
                2'b10: count_ff <= count_ff + 2'h1;
                2'b01: count_ff <= count_ff - 2'h1;
                default: count_ff <= count_ff;
            endcase
        end
    end
endmodule

// file: logic/scp_serial_pins.sv
`timescale 1ns/1ns
`include "scp_regs.svh"
// Summary of operation
// R1 - async transmission waits while clear-to-send inactive; sync mode ignores it
// R2 - baud timing from internal or external clock
// R3 - external baud clock at most half clk
// R4 - synchronous mode: transmit pin is clock
// R5 - synchronous mode: receive pin bidirectional
// R6 - channel 1 transmit-complete interrupt output
// R7 - channel 1 receive-complete interrupt output
// R8 - serial pins selectable as port bits
// R9 - interrupt outputs selectable as port outputs
// R10 - pin selection registers with reset default
module scp_serial_pins (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cfgLoad,
    input wire logic [7:0] cfgBSel,
    input wire logic [1:0] cfgCSel,
    input wire logic [1:0] syncMode,
    input wire logic [1:0] extClkSel,
    input wire logic [1:0] rxEnable,
    input wire logic [15:0] baudDiv,
    input wire logic [15:0] txData,
    input wire logic [1:0] txValid,
    output logic [1:0] txReady,
    output logic [15:0] rxData,
    output logic [1:0] rxValid,
    input wire logic [1:0] rxReady,
    input wire logic [1:0] irqAck,
    input wire logic [7:0] portBOut,
    input wire logic [7:0] portBDrv,
    input wire logic [1:0] portCOut,
    output logic [7:0] portBIn,
    input wire logic [7:0] padBIn,
    output logic [7:0] padBOut,
    output logic [7:0] padBOeN,
    output logic [1:0] padCOut
);
    logic [7:0] padMeta_ff;
    logic [7:0] padSync_ff;
    logic [7:0] selB_ff;
    logic [1:0] selC_ff;
    logic [7:0] serOut;
    logic [7:0] serOeN;
    logic [1:0] txDoneV;
    logic [1:0] rxDoneV;
    logic txIrq_ff;
    logic rxIrq_ff;
    logic [7:0] padBOut_ff;
    logic [7:0] padBOeN_ff;
    logic [1:0] padCOut_ff;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    // pads are asynchronous to clk; first stage read only by the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            padMeta_ff <= 8'h00;
            padSync_ff <= 8'h00;
        end else if (ce) begin
            padMeta_ff <= padBIn;
            padSync_ff <= padMeta_ff;
        end
    end
    assign portBIn = padSync_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            selB_ff <= `SCP_BSEL_RST; // R10
            selC_ff <= `SCP_CSEL_RST; // R10
        end else if (ce && cfgLoad) begin
            selB_ff <= cfgBSel;
            selC_ff <= cfgCSel;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            localparam int B = ch * `SCP_CH_STRIDE;
            scp_pkg::scp_tx_state_t txState_ff;
            scp_pkg::scp_rx_state_t rxState_ff;
            logic [7:0] divCnt_ff;
            logic bclkPrev_ff;
            logic [3:0] txSub_ff;
            logic [3:0] txBit_ff;
            logic [9:0] txShift_ff;
            logic [3:0] rxSub_ff;
            logic [3:0] rxBit_ff;
            logic [7:0] rxShift_ff;
            logic bclkS;
            logic rxS;
            logic ctsOk;
            logic bclkEdge;
            logic tick;
            logic txqValid;
            logic [7:0] txqData;
            logic txqPop;
            logic rxqReady;
            logic aRxPush;
            logic sRxPush;
            logic rxPush;
            logic [7:0] rxWord;
            logic inSync;

            assign bclkS = padSync_ff[B + `SCP_P_BCLK];
            assign rxS = padSync_ff[B + `SCP_P_RX];
            // clear-to-send is active low; a port-mode pin never blocks
            assign ctsOk = ~selB_ff[B + `SCP_P_CTS] | ~padSync_ff[B + `SCP_P_CTS];
            // edge found by sampling, so the baud clock must stay below clk/2
            assign bclkEdge = bclkS & ~bclkPrev_ff; // R3
            assign tick = ce & (extClkSel[ch] ? bclkEdge : (divCnt_ff == 8'h00)); // R2

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    divCnt_ff <= 8'h00;
                    bclkPrev_ff <= 1'b0;
                end else if (ce) begin
                    divCnt_ff <= (divCnt_ff == 8'h00) ? baudDiv[ch*8 +: 8] : divCnt_ff - 8'h01;
                    bclkPrev_ff <= bclkS;
                end
            end

            scp_fifo2 u_txq (
                .clk(clk), .resetn(resetn), .ce(ce),
                .inValid(txValid[ch]), .inReady(txReady[ch]), .inData(txData[ch*8 +: 8]),
                .outValid(txqValid), .outReady(txqPop), .outData(txqData)
            );
            scp_fifo2 u_rxq (
                .clk(clk), .resetn(resetn), .ce(ce),
                .inValid(rxPush), .inReady(rxqReady), .inData(rxWord),
                .outValid(rxValid[ch]), .outReady(rxReady[ch]), .outData(rxData[ch*8 +: 8])
            );

            assign txqPop = tick & (txState_ff == scp_pkg::TX_IDLE) & txqValid & (syncMode[ch] | ctsOk); // R1
            assign inSync = (txState_ff == scp_pkg::TX_SYNC) | (txState_ff == scp_pkg::TX_SRX);

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    txState_ff <= scp_pkg::TX_IDLE;
                    txSub_ff <= 4'h0;
                    txBit_ff <= 4'h0;
                    txShift_ff <= `SCP_TX_IDLE_SHIFT;
                end else if (tick) begin
                    case (txState_ff)
                        scp_pkg::TX_IDLE: begin
                            txSub_ff <= 4'h0;
                            txBit_ff <= 4'h0;
                            if (txqPop) begin
                                txState_ff <= syncMode[ch] ? scp_pkg::TX_SYNC : scp_pkg::TX_ASYNC;
                                txShift_ff <= syncMode[ch] ? {2'b11, txqData} : {1'b1, txqData, 1'b0};
                            end else if (syncMode[ch] && rxEnable[ch] && rxqReady) begin
                                txState_ff <= scp_pkg::TX_SRX;
                            end
                        end
                        scp_pkg::TX_ASYNC: begin
                            txSub_ff <= txSub_ff + 4'h1;
                            if (txSub_ff == `SCP_OVS_LAST) begin
                                txShift_ff <= {1'b1, txShift_ff[9:1]};
                                txBit_ff <= txBit_ff + 4'h1;
                                if (txBit_ff == `SCP_AFRAME_LAST) begin
                                    txState_ff <= scp_pkg::TX_IDLE;
                                end
                            end
                        end
                        default: begin
                            // half-bit phase: low then high; receive samples at the end of high, as the
                            // pad input lags two flops; needs at least two clk per tick
                            txSub_ff <= {3'b000, ~txSub_ff[0]}; // R4
                            if (txSub_ff[0]) begin
                                txShift_ff <= {(txState_ff == scp_pkg::TX_SRX) ? rxS : 1'b1, txShift_ff[9:1]}; // R5
                                txBit_ff <= txBit_ff + 4'h1;
                                if (txBit_ff == `SCP_SBIT_LAST) begin
                                    txState_ff <= scp_pkg::TX_IDLE;
                                    txShift_ff <= `SCP_TX_IDLE_SHIFT;
                                end
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    rxState_ff <= scp_pkg::RX_IDLE;
                    rxSub_ff <= 4'h0;
                    rxBit_ff <= 4'h0;
                    rxShift_ff <= 8'h00;
                end else if (tick) begin
                    case (rxState_ff)
                        scp_pkg::RX_IDLE: begin
                            rxSub_ff <= 4'h0;
                            rxBit_ff <= 4'h0;
                            if (!syncMode[ch] && rxEnable[ch] && !rxS) begin
                                rxState_ff <= scp_pkg::RX_BUSY;
                            end
                        end
                        default: begin
                            rxSub_ff <= rxSub_ff + 4'h1;
                            if (rxSub_ff == `SCP_MID) begin
                                rxBit_ff <= rxBit_ff + 4'h1;
                                // glitch on the start bit is dropped; stop bit ends early to resync
                                if ((rxBit_ff == 4'h0 && rxS) || rxBit_ff == `SCP_AFRAME_LAST) begin
                                    rxState_ff <= scp_pkg::RX_IDLE;
                                end else if (rxBit_ff != 4'h0) begin
                                    rxShift_ff <= {rxS, rxShift_ff[7:1]};
                                end
                            end
                        end
                    endcase
                end
            end

            // a full receive buffer drops the word; sync receive only starts with room
            assign aRxPush = tick & (rxState_ff == scp_pkg::RX_BUSY) & (rxSub_ff == `SCP_MID)
                & (rxBit_ff == `SCP_AFRAME_LAST) & rxS;
            assign sRxPush = tick & (txState_ff == scp_pkg::TX_SRX) & txSub_ff[0] & (txBit_ff == `SCP_SBIT_LAST);
            assign rxPush = aRxPush | sRxPush;
            assign rxWord = aRxPush ? rxShift_ff : {rxS, txShift_ff[9:3]};
            assign rxDoneV[ch] = rxPush & rxqReady;
            assign txDoneV[ch] = tick & (((txState_ff == scp_pkg::TX_ASYNC) & (txSub_ff == `SCP_OVS_LAST)
                & (txBit_ff == `SCP_AFRAME_LAST)) | ((txState_ff == scp_pkg::TX_SYNC) & txSub_ff[0]
                & (txBit_ff == `SCP_SBIT_LAST)));

            assign serOut[B + `SCP_P_TX] = syncMode[ch] ? (inSync ? txSub_ff[0] : 1'b1) : txShift_ff[0]; // R4
            assign serOeN[B + `SCP_P_TX] = 1'b0;
            assign serOut[B + `SCP_P_RX] = txShift_ff[0];
            assign serOeN[B + `SCP_P_RX] = ~(txState_ff == scp_pkg::TX_SYNC); // R5
            assign serOut[B + `SCP_P_BCLK] = 1'b0;
            assign serOeN[B + `SCP_P_BCLK] = 1'b1;
            assign serOut[B + `SCP_P_CTS] = 1'b0;
            assign serOeN[B + `SCP_P_CTS] = 1'b1;

            sequence txStart_s;
                txState_ff == scp_pkg::TX_IDLE ##1 txState_ff == scp_pkg::TX_ASYNC;
            endsequence
            cts_gate_a: assert property (txStart_s |-> $past(ctsOk)) // R1
                else $error("async transmit started without clear-to-send");
            ext_tick_a: assert property ((extClkSel[ch] && !bclkEdge && txState_ff == scp_pkg::TX_ASYNC)
                |=> $stable(txSub_ff) && $stable(txShift_ff)) // R2
                else $error("transmit advanced without an external baud edge");
            sync_clk_a: assert property ((ce && selB_ff[B + `SCP_P_TX] && syncMode[ch] && inSync)
                |=> padBOut_ff[B + `SCP_P_TX] == $past(txSub_ff[0])) // R4
                else $error("transmit pin not carrying the sync clock");
            rx_drive_a: assert property ((ce && selB_ff[B + `SCP_P_RX] && txState_ff == scp_pkg::TX_SYNC)
                |=> !padBOeN_ff[B + `SCP_P_RX] && padBOut_ff[B + `SCP_P_RX] == $past(txShift_ff[0])) // R5
                else $error("receive pin not driving sync transmit data");
            rx_float_a: assert property ((ce && selB_ff[B + `SCP_P_RX] && txState_ff == scp_pkg::TX_SRX)
                |=> padBOeN_ff[B + `SCP_P_RX]) // R5
                else $error("receive pin driven during sync reception");
        end
    endgenerate

    // set wins over acknowledge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            txIrq_ff <= 1'b0;
            rxIrq_ff <= 1'b0;
        end else if (ce) begin
            txIrq_ff <= txDoneV[1] | (txIrq_ff & ~irqAck[1]); // R6
            rxIrq_ff <= rxDoneV[1] | (rxIrq_ff & ~irqAck[0]); // R7
        end
    end

    // pins registered one cycle after the selection mux
    always_ff @(posedge clk) begin
        if (!resetn) begin
            padBOut_ff <= 8'h00;
            padBOeN_ff <= 8'hFF;
            padCOut_ff <= 2'h0;
        end else if (ce) begin
            padBOut_ff <= (selB_ff & serOut) | (~selB_ff & portBOut); // R8
            padBOeN_ff <= (selB_ff & serOeN) | (~selB_ff & ~portBDrv); // R8
            padCOut_ff[`SCP_C_TXI] <= selC_ff[`SCP_C_TXI] ? txIrq_ff : portCOut[`SCP_C_TXI]; // R9
            padCOut_ff[`SCP_C_RXI] <= selC_ff[`SCP_C_RXI] ? rxIrq_ff : portCOut[`SCP_C_RXI]; // R9
        end
    end
    assign padBOut = padBOut_ff;
    assign padBOeN = padBOeN_ff;
    assign padCOut = padCOut_ff;

    tx_irq_a: assert property ((ce && txDoneV[1]) |=> txIrq_ff ##1 (txIrq_ff || $past(irqAck[1]) || !$past(ce))) // R6
        else $error("transmit interrupt not raised or lost");
    rx_irq_a: assert property ((ce && rxIrq_ff && !irqAck[0]) |=> rxIrq_ff) // R7
        else $error("receive interrupt dropped without acknowledge");
    rx_irq_set_a: assert property ((ce && rxDoneV[1]) |=> rxIrq_ff) // R7
        else $error("receive interrupt not raised");
    port_mux_a: assert property (ce |=> padBOut_ff == (($past(selB_ff) & $past(serOut))
        | (~$past(selB_ff) & $past(portBOut)))) // R8
        else $error("port b output selection wrong");
    irq_port_a: assert property ((ce && !selC_ff[`SCP_C_TXI])
        |=> padCOut_ff[`SCP_C_TXI] == $past(portCOut[`SCP_C_TXI])) // R9
        else $error("port c bit not following port value");
    cfg_reset_a: assert property (disable iff (1'b0) !resetn |=> selB_ff == `SCP_BSEL_RST
        && selC_ff == `SCP_CSEL_RST && padBOeN_ff == 8'hFF) // R10
        else $error("pin selection not at reset default");
endmodule

// file: test/scp_serial_peer.sv
`timescale 1ns/1ns
module scp_serial_peer (
    input wire logic txLine,
    input wire logic rxSense,
    input wire logic devDrivesRx,
    input wire logic syncMode,
    output logic rxDrive,
    output logic rxDriveEn,
    output logic ctsN,
    output logic baudClk,
    output logic [7:0] gotByte,
    output logic gotStrobe
);
    int bitNs = 3200;
    bit baudRun = 1'b0;
    logic [7:0] syncOut = 8'h00;
    logic [7:0] shiftIn = 8'h00;
    int txIdx = 0;
    int rxIdx = 0;
    initial begin
        {rxDrive, rxDriveEn, ctsN, baudClk} = 4'hA;
        {gotByte, gotStrobe} = 9'h000;
    end
    // odd filler step starts baud edges at an arbitrary but fixed phase against clk
    always begin
        #(baudRun ? 400 : 13);
        baudClk = baudRun ? ~baudClk : 1'b0;
    end
    task automatic report(input logic [7:0] b);
        gotByte = b;
        gotStrobe = 1'b1;
        #1 gotStrobe = 1'b0;
    endtask
    always @(negedge txLine) begin : async_rx
        logic [7:0] b;
        if (!syncMode) begin
            #(bitNs / 2);
            if (txLine === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    #(bitNs);
                    b[i] = txLine;
                end
                #(bitNs);
                if (txLine === 1'b1) report(b);
            end
        end
    end
    // wait one step so the device enable of the same edge is seen
    always @(negedge txLine) begin
        #1;
        if (syncMode && !devDrivesRx) begin
            rxDriveEn = 1'b1;
            rxDrive = syncOut[txIdx];
            txIdx++;
        end
    end
    always @(posedge txLine) begin
        #1;
        if (syncMode && devDrivesRx) begin
            shiftIn[rxIdx] = rxSense;
            rxIdx++;
            if (rxIdx == 8) begin
                rxIdx = 0;
                report(shiftIn);
            end
        end
        if (txIdx == 8) begin
            txIdx = 0;
            rxDriveEn = 1'b0;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        rxDriveEn = 1'b1;
        rxDrive = 1'b0;
        #(bitNs);
        for (int i = 0; i < 8; i++) begin
            rxDrive = b[i];
            #(bitNs);
        end
        rxDrive = 1'b1;
        #(bitNs);
        rxDriveEn = 1'b0;
        // let a clock edge pass before the next frame
        #100;
    endtask
endmodule

// file: test/tb_serial_channel_pin_logic.sv
`timescale 1ns/1ns
module tb_serial_channel_pin_logic;
    logic clk = 1'b0;
    logic resetn, ce, cfgLoad;
    logic [7:0] cfgBSel, portBOut, portBDrv, portBIn, padBIn, padBOut, padBOeN;
    logic [1:0] cfgCSel, syncMode, extClkSel, rxEnable, txValid, txReady, rxValid, rxReady;
    logic [1:0] irqAck, portCOut, padCOut, pRx, pRxEn, pCtsN, pBaud, pGot;
    logic [15:0] baudDiv, txData, rxData;
    logic [7:0] pByte [2];
    logic [7:0] txQ [2][$];
    logic [7:0] rxQ [2][$];
    int errors = 0;
    int checks = 0;
    always #50 clk = ~clk;
    // released serial lines idle high through a pull-up
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            padBIn[c*4] = !padBOeN[c*4] ? padBOut[c*4] : (pRxEn[c] ? pRx[c] : 1'b1);
            padBIn[c*4+1] = !padBOeN[c*4+1] ? padBOut[c*4+1] : 1'b1;
            padBIn[c*4+2] = !padBOeN[c*4+2] ? padBOut[c*4+2] : pBaud[c];
            padBIn[c*4+3] = !padBOeN[c*4+3] ? padBOut[c*4+3] : pCtsN[c];
        end
    end
    scp_serial_pins scp_serial_pins_i (
        .clk(clk), .resetn(resetn), .ce(ce), .cfgLoad(cfgLoad), .cfgBSel(cfgBSel), .cfgCSel(cfgCSel),
        .syncMode(syncMode), .extClkSel(extClkSel), .rxEnable(rxEnable), .baudDiv(baudDiv),
        .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .rxReady(rxReady), .irqAck(irqAck), .portBOut(portBOut), .portBDrv(portBDrv), .portCOut(portCOut),
        .portBIn(portBIn), .padBIn(padBIn), .padBOut(padBOut), .padBOeN(padBOeN), .padCOut(padCOut)
    );
    for (genvar c = 0; c < 2; c++) begin : peer
        scp_serial_peer scp_serial_peer_i (
            .txLine(padBIn[c*4+1]), .rxSense(padBIn[c*4]), .devDrivesRx(!padBOeN[c*4]),
            .syncMode(syncMode[c]), .rxDrive(pRx[c]), .rxDriveEn(pRxEn[c]), .ctsN(pCtsN[c]),
            .baudClk(pBaud[c]), .gotByte(pByte[c]), .gotStrobe(pGot[c])
        );
    end
    task automatic check_val(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic push_tx(input int c, input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk);
        #10;
        txData[c*8+:8] = b;
        txValid[c] = 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (txReady[c] !== 1'b1 && n < 4000);
        #10;
        txValid[c] = 1'b0;
        txQ[c].push_back(b);
    endtask
    task automatic drain(input int c);
        int n;
        n = 0;
        while (txQ[c].size() != 0 && n < 4000) begin
            cyc(1);
            n++;
        end
    endtask
    always @(posedge pGot[0]) check_val("tx word ch0", pByte[0], txQ[0].size() ? txQ[0].pop_front() : 8'hXX);
    always @(posedge pGot[1]) check_val("tx word ch1", pByte[1], txQ[1].size() ? txQ[1].pop_front() : 8'hXX);
    always @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (rxValid[c] && rxReady[c]) begin
                check_val("rx word", rxData[c*8+:8], rxQ[c].size() ? rxQ[c].pop_front() : 8'hXX);
            end
        end
    end
    initial begin
        #3000000;
        errors++;
        final_report();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] r [3];
        int n;
        void'($urandom(32'hD99E));
        {resetn, cfgLoad, cfgBSel, cfgCSel, syncMode, extClkSel, rxEnable, txData, txValid} = '0;
        {irqAck, portBOut, portBDrv, portCOut, rxReady} = '0;
        ce = 1'b1;
        baudDiv = 16'h0101;
        repeat (3) @(posedge clk);
        #10 resetn = 1'b1;
        check_val("pad b enable", padBOeN, 8'hFF);
        check_val("pad b out", padBOut, 8'h00);
        check_val("reset flags", {2'b00, padCOut, txReady, rxValid}, 8'h0C);
        v = 8'($urandom());
        portBOut = v;
        portBDrv = 8'hFF;
        portCOut = 2'($urandom());
        cyc(2);
        check_val("pad b port out", padBOut, v);
        check_val("pad b port enable", padBOeN, 8'h00);
        check_val("pad c port out", {6'h00, padCOut}, {6'h00, portCOut});
        ce = 1'b0;
        portBOut = ~v;
        cyc(2);
        check_val("pad b frozen", padBOut, v);
        ce = 1'b1;
        portBOut = v;
        cyc(2);
        check_val("pad b resumed", padBOut, v);
        portBDrv = 8'h00;
        cyc(4);
        check_val("port b in", portBIn, 8'hBB);
        cfgBSel = 8'hFF;
        cfgCSel = 2'b11;
        rxEnable = 2'b11;
        rxReady = 2'b11;
        cfgLoad = 1'b1;
        cyc(1);
        cfgLoad = 1'b0;
        for (int c = 0; c < 2; c++) repeat (2) push_tx(c, 8'($urandom()));
        cyc(400);
        check_val("tx ready while blocked", {6'h00, txReady}, 8'h00);
        check_val("words held", 8'(txQ[0].size() + txQ[1].size()), 8'h04);
        peer[0].scp_serial_peer_i.ctsN = 1'b0;
        peer[1].scp_serial_peer_i.ctsN = 1'b0;
        drain(0);
        drain(1);
        cyc(40);
        check_val("tx done irq", {7'h00, padCOut[1]}, 8'h01);
        irqAck = 2'b10;
        cyc(1);
        irqAck = 2'b00;
        cyc(2);
        check_val("irq cleared", {6'h00, padCOut}, 8'h00);
        // third word meets a full buffer and is lost
        rxReady = 2'b00;
        v = 8'($urandom());
        foreach (r[i]) r[i] = 8'($urandom());
        rxQ[0].push_back(v);
        rxQ[1].push_back(r[0]);
        rxQ[1].push_back(r[1]);
        fork
            peer[0].scp_serial_peer_i.send_byte(v);
            for (int i = 0; i < 3; i++) peer[1].scp_serial_peer_i.send_byte(r[i]);
        join
        cyc(40);
        check_val("rx valid while stalled", {6'h00, rxValid}, 8'h03);
        check_val("rx done irq", {7'h00, padCOut[0]}, 8'h01);
        rxReady = 2'b11;
        irqAck = 2'b01;
        cyc(1);
        irqAck = 2'b00;
        cyc(4);
        check_val("rx drained", 8'(rxQ[0].size() + rxQ[1].size()), 8'h00);
        check_val("rx irq cleared", {7'h00, padCOut[0]}, 8'h00);
        extClkSel = 2'b01;
        peer[0].scp_serial_peer_i.bitNs = 12800;
        peer[0].scp_serial_peer_i.baudRun = 1'b1;
        v = 8'($urandom());
        rxQ[0].push_back(v);
        push_tx(0, 8'($urandom()));
        peer[0].scp_serial_peer_i.send_byte(v);
        drain(0);
        cyc(200);
        check_val("ext clock words", 8'(rxQ[0].size() + txQ[0].size()), 8'h00);
        peer[0].scp_serial_peer_i.baudRun = 1'b0;
        extClkSel = 2'b00;
        syncMode = 2'b01;
        rxEnable = 2'b10;
        push_tx(0, 8'($urandom()));
        n = 0;
        while (padBOut[1] !== 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        check_val("sync pin drive", {6'h00, padBOeN[1:0]}, 8'h00);
        drain(0);
        cyc(20);
        check_val("sync clock idle", {7'h00, padBOut[1]}, 8'h01);
        v = 8'($urandom());
        peer[0].scp_serial_peer_i.syncOut = v;
        rxQ[0].push_back(v);
        rxQ[0].push_back(v);
        rxReady = 2'b10;
        rxEnable = 2'b11;
        cyc(200);
        rxEnable = 2'b10;
        check_val("sync rx held", {7'h00, rxValid[0]}, 8'h01);
        cyc(60);
        rxReady = 2'b11;
        cyc(4);
        check_val("pending words", 8'(rxQ[0].size() + txQ[0].size()), 8'h00);
        final_report();
    end
endmodule
